// file: sesrc_pkg.sv
// package: constants and types of the serial eeprom command front end
package sesrc_pkg;

   // array geometry
   localparam int           ADDR_W        = 11;        // array address bits used
   localparam int           MEM_DEPTH     = 2048;      // bytes in the array
   localparam int           XFER_ADDR_W   = 16;        // address bits sent on the link
   localparam int           PAGE_W        = 5;         // low bits that roll inside a page

   // op-code layout: upper nibble must be zero, bit 3 ignored
   localparam int           OP_HI_MSB     = 7;
   localparam int           OP_HI_LSB     = 4;
   localparam int           OP_CODE_MSB   = 2;

   // command codes held in op-code bits 2..0
   typedef enum logic [2:0] {
      CMD_SET_WEL  = 3'h6,                             // set_write_latch_cmd
      CMD_CLR_WEL  = 3'h4,                             // clear_write_latch_cmd
      CMD_RD_STAT  = 3'h5,                             // read_status_cmd
      CMD_WR_STAT  = 3'h1,                             // write_status_cmd
      CMD_RD_ARRAY = 3'h3,                             // array read
      CMD_WR_ARRAY = 3'h2                              // array write
   } sesrc_cmd_t;

   // status register field positions
   localparam int           ST_RDY_BIT    = 0;         // ready_not_flag
   localparam int           ST_WEL_BIT    = 1;         // write enable latch
   localparam int           ST_BPL_BIT    = 2;         // block_protect_lo
   localparam int           ST_BPH_BIT    = 3;         // block_protect_hi
   localparam int           ST_ARM_BIT    = 7;         // hw_protect_arm
   localparam logic [7:0]   STAT_BUSY     = 8'hff;     // every bit reads 1 while busy

   // reset and shipped values
   localparam logic         WEL_RST       = 1'b0;
   localparam logic [1:0]   BP_SHIP       = 2'h0;
   localparam logic         ARM_SHIP      = 1'b0;

   // block protect range bases
   localparam logic [10:0]  BP_QUART_BASE = 11'h600;
   localparam logic [10:0]  BP_HALF_BASE  = 11'h400;

   // link bit counter landmarks (value of the count before the edge)
   localparam logic [5:0]   CNT_OP_LAST   = 6'h07;     // eighth rising edge
   localparam logic [5:0]   CNT_OP_DONE   = 6'h08;     // op-code complete
   localparam logic [5:0]   CNT_STAT_LAST = 6'h0f;     // sixteenth rising edge
   localparam logic [5:0]   CNT_ADDR_LAST = 6'h17;     // last address edge
   localparam logic [5:0]   CNT_DATA0     = 6'h18;     // first data bit slot
   localparam logic [5:0]   CNT_BYTE_LAST = 6'h1f;     // last edge of a data byte

   // internal write cycle time
   localparam int           T_WRITE_NS    = 5000000;   // self-timed write, 5 ms
   localparam int           CLK_PERIOD_NS = 100;       // clk_in period
   localparam int           WRITE_CYCLES  = T_WRITE_NS / CLK_PERIOD_NS;

   // internal write engine states
   typedef enum logic {
      ENG_IDLE = 1'b0,
      ENG_BUSY = 1'b1
   } sesrc_state_t;

endpackage : sesrc_pkg

// file: sesrc_core.sv
// serial eeprom command front end: link shifter, status register, array and write engine
//
// Contract
// - status register writable only unprotected and latched
// - bit 0 busy flag; busy accepts only status read
// - bit 1 is write latch; power-up clear
// - block protect bits nonvolatile, shipped as zero
// - bits 4..6 not stored, read zero
// - arm bit plus low pin protects status only
// - arm cannot clear while protect pin low
// - all status bits read one while busy
// - block protect pair selects protected array range
// - block protection independent of other protection
// - sample input on rising clock, op-code first
// - output bits change on falling clock
// - all fields travel most significant first
// - latch and status op-codes, bit 3 ignored
// - status write and array op-codes decoded
// - latch clears after disable, status or array write
// - status byte repeats while clocking continues
// - status write keeps only protect and arm bits
// - status bits update together at cycle end
// - array read streams incrementing addresses, wraps
// - only low eleven address bits select
`timescale 1ns/1ps
module sesrc_core #(
   parameter int WRITE_CYC = sesrc_pkg::WRITE_CYCLES      // internal write length in clk_in cycles
) (
   input  wire logic clk_in,                              // system clock, 10 MHz
   input  wire logic rst_in,                              // power-up reset, active high
   input  wire logic sck_in,                              // serial clock from the master
   input  wire logic cs_n_in,                             // chip select, active low
   input  wire logic si_in,                               // serial data in
   input  wire logic wp_n_in,                             // write protect pin, active low
   output logic      so_out,                              // serial data out
   output logic      so_oe_n_out                          // low while so_out is driven
);
   import sesrc_pkg::*;

   // refuse write lengths the cycle counter cannot hold
   if (WRITE_CYC < 1 || WRITE_CYC > 65535) begin : g_bad_cyc
      $error("sesrc_core: WRITE_CYC out of range");
   end

   // ------------------------------------------------------------------
   // shared storage
   // ------------------------------------------------------------------
   logic [7:0]       mem_q [MEM_DEPTH];                   // the array, not reset (nonvolatile)
   logic [1:0]       bp_q  = BP_SHIP;                     // block protect hi/lo, shipped value
   logic             arm_q = ARM_SHIP;                    // hw_protect_arm, shipped value
   logic             wel_q;                               // write enable latch
   sesrc_state_t     state_q;                             // write engine state

   // ------------------------------------------------------------------
   // link side, clocked by sck_in
   // ------------------------------------------------------------------
   logic             link_rst;                            // frame reset: select high or power-up
   logic [5:0]       cnt_q;                               // rising edges seen this frame
   logic [5:0]       cnt_d;
   logic [15:0]      sh_q;                                // input shifter
   logic [15:0]      sh_d;
   logic [7:0]       op_q;                                // op-code of the current frame
   logic [10:0]      ptr_q;                               // running array pointer
   logic [10:0]      ptr_d;
   logic             rec_ok_q;                            // frame ended on a legal boundary
   logic             rec_ok_d;
   logic             frame_tog_q;                         // flips on the first edge of a frame
   logic [10:0]      rec_addr_q;                          // address of last whole write byte
   logic [7:0]       rec_data_q;                          // last whole data byte
   logic             busy_m_q;                            // busy synchroniser, first stage
   logic             busy_s_q;                            // busy synchroniser, second stage
   logic             so_q;                                // output bit, falling edge
   logic             so_en_q;                             // output enable, falling edge

   // frame logic is cleared whenever select is high
   assign link_rst = rst_in | cs_n_in;

   // serial input, most significant bit first
   assign sh_d = {sh_q[14:0], si_in};

   // count wraps within the data phase so low bits keep the byte slot
   assign cnt_d = (cnt_q == CNT_BYTE_LAST) ? CNT_DATA0 : cnt_q + 6'h01;

   // op-code decode of the current frame
   wire              op_done  = (cnt_q >= CNT_OP_DONE);   // op_q belongs to this frame
   wire              op_legal = (op_q[OP_HI_MSB:OP_HI_LSB] == 4'h0);
   wire [2:0]        op_code  = op_q[OP_CODE_MSB:0];      // bit 3 dropped
   wire              is_read_status_cmd  = op_done & op_legal & (op_code == CMD_RD_STAT);
   wire              is_rd    = op_done & op_legal & (op_code == CMD_RD_ARRAY)
                                & ~busy_s_q;              // busy refuses reads
   wire              is_write_status_cmd  = op_done & op_legal & (op_code == CMD_WR_STAT);
   wire              is_wr    = op_done & op_legal & (op_code == CMD_WR_ARRAY);

   // op-code arriving on the eighth edge, for the one-byte commands
   wire [7:0]        op_new   = sh_d[7:0];
   wire              new_latch = (op_new[OP_HI_MSB:OP_HI_LSB] == 4'h0) &
                                 ((op_new[OP_CODE_MSB:0] == CMD_SET_WEL) |
                                  (op_new[OP_CODE_MSB:0] == CMD_CLR_WEL));

   // a command counts only if select rises right after its last bit
   always_comb begin
      rec_ok_d = 1'b0;                                    // any extra edge spoils it
      if (cnt_q == CNT_OP_LAST) begin
         rec_ok_d = new_latch;                            // exactly eight bits
      end else if (cnt_q == CNT_STAT_LAST) begin
         rec_ok_d = is_write_status_cmd;                              // exactly sixteen bits
      end else if (cnt_q == CNT_BYTE_LAST) begin
         rec_ok_d = is_wr;                                // whole data bytes only
      end
   end

   // pointer: load low address bits, then step per byte
   always_comb begin
      ptr_d = ptr_q;
      if (cnt_q == CNT_ADDR_LAST && (is_rd || is_wr)) begin
         ptr_d = sh_d[ADDR_W-1:0];                        // upper five ignored
      end else if (cnt_q == CNT_BYTE_LAST && is_rd) begin
         ptr_d = ptr_q + 11'h001;                         // wraps past the top
      end else if (cnt_q == CNT_BYTE_LAST && is_wr) begin
         ptr_d = {ptr_q[ADDR_W-1:PAGE_W], ptr_q[PAGE_W-1:0] + 5'h01}; // rolls in page
      end
   end

   // frame counter and shifter, cleared by select
   always_ff @(posedge sck_in or posedge link_rst) begin
      if (link_rst) begin
         cnt_q <= 6'h00;
         sh_q  <= 16'h0000;
      end else begin
         cnt_q <= cnt_d;
         sh_q  <= sh_d;                                   // sampled on rising edge
      end
   end

   // command record; survives select high so the engine can read it
   always_ff @(posedge sck_in or posedge rst_in) begin
      if (rst_in) begin
         op_q       <= 8'h00;
         ptr_q      <= 11'h000;
         rec_ok_q   <= 1'b0;
         rec_addr_q <= 11'h000;
         rec_data_q <= 8'h00;
         frame_tog_q <= 1'b0;
      end else begin
         if (cnt_q == CNT_OP_LAST) begin
            op_q <= op_new;                               // first field is the op-code
         end
         ptr_q    <= ptr_d;
         rec_ok_q <= rec_ok_d;
         if (cnt_q == 6'h00) begin
            frame_tog_q <= ~frame_tog_q;                  // a frame that carried clocks
         end
         if (cnt_q == CNT_STAT_LAST || (cnt_q == CNT_BYTE_LAST && is_wr)) begin
            rec_data_q <= sh_d[7:0];
            rec_addr_q <= ptr_q;
         end
      end
   end

   // busy level into the link domain; stalls while sck is quiet, fresh after a few edges
   always_ff @(posedge sck_in or posedge rst_in) begin
      if (rst_in) begin
         busy_m_q <= 1'b0;
         busy_s_q <= 1'b0;
      end else begin
         busy_m_q <= (state_q == ENG_BUSY);
         busy_s_q <= busy_m_q;
      end
   end

   // status word as read; bp, arm and wel can also move mid-frame, when a write cycle ends
   logic [7:0]       stat_word;
   always_comb begin
      stat_word              = 8'h00;                     // bits 4..6 read zero
      stat_word[ST_RDY_BIT]  = 1'b0;                      // ready
      stat_word[ST_WEL_BIT]  = wel_q;
      stat_word[ST_BPL_BIT]  = bp_q[0];
      stat_word[ST_BPH_BIT]  = bp_q[1];
      stat_word[ST_ARM_BIT]  = arm_q;
      if (busy_s_q) begin
         stat_word = STAT_BUSY;
      end
   end

   // array data is stable here: the engine only writes while reads are refused
   wire [7:0]        tx_byte = is_read_status_cmd ? stat_word : mem_q[ptr_q];
   wire              tx_on   = is_read_status_cmd | (is_rd & (cnt_q >= CNT_DATA0));
   wire [2:0]        tx_idx  = 3'h7 - cnt_q[2:0];         // msb first

   // output shifter on the falling edge; floats whenever select is high
   always_ff @(negedge sck_in or posedge link_rst) begin
      if (link_rst) begin
         so_q    <= 1'b0;
         so_en_q <= 1'b0;
      end else begin
         so_q    <= tx_byte[tx_idx];
         so_en_q <= tx_on;
      end
   end

   assign so_out      = so_q;
   assign so_oe_n_out = ~so_en_q;

   // ------------------------------------------------------------------
   // engine side, clocked by clk_in
   // ------------------------------------------------------------------
   logic             cs_m_q;                              // select synchroniser, first stage
   logic             cs_s_q;                              // select synchroniser, second stage
   logic             cs_e_q;                              // delayed copy for edge detect
   logic             wp_m_q;                              // protect pin, first stage
   logic             wp_s_q;                              // protect pin, second stage
   logic [15:0]      cyc_q;                               // write cycle counter
   logic             pend_stat_q;                         // pending job is a status write
   logic [1:0]       pend_bp_q;                           // new protect bits
   logic             pend_arm_q;                          // new arm bit
   logic [10:0]      pend_addr_q;                         // array target
   logic [7:0]       pend_data_q;                         // array data
   logic             used_tog_q;                          // frame marker already acted upon

   // synchronise select and the protect pin
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cs_m_q <= 1'b1;
         cs_s_q <= 1'b1;
         cs_e_q <= 1'b1;
         wp_m_q <= 1'b1;
         wp_s_q <= 1'b1;
      end else begin
         cs_m_q <= cs_n_in;
         cs_s_q <= cs_m_q;
         cs_e_q <= cs_s_q;
         wp_m_q <= wp_n_in;
         wp_s_q <= wp_m_q;
      end
   end

   // the record is frozen once select is high, as sck stops before it rises
   wire              cs_rise  = cs_s_q & ~cs_e_q;
   wire              rec_legal = (op_q[OP_HI_MSB:OP_HI_LSB] == 4'h0);
   wire [2:0]        rec_code = op_q[OP_CODE_MSB:0];
   // a select pulse with no clocks must not replay the previous record
   wire              fresh    = frame_tog_q ^ used_tog_q;
   wire              take     = cs_rise & fresh & rec_ok_q & rec_legal
                                & (state_q == ENG_IDLE);  // busy takes nothing
   wire              hw_prot  = arm_q & ~wp_s_q;
   wire              stat_ok  = wel_q & ~hw_prot;

   // block protection looks at the range only
   wire              blk_prot = (bp_q == 2'h3) |
                                ((bp_q == 2'h2) & (rec_addr_q >= BP_HALF_BASE)) |
                                ((bp_q == 2'h1) & (rec_addr_q >= BP_QUART_BASE));
   wire              arr_ok   = wel_q & ~blk_prot;

   // arm may only drop when the pin is already high
   wire              arm_new  = rec_data_q[ST_ARM_BIT] | (arm_q & ~wp_s_q);
   wire              cyc_end  = (cyc_q == 16'(WRITE_CYC - 1));
   wire              done     = (state_q == ENG_BUSY) & cyc_end;

   // write engine: command launch at select rise, self-timed cycle
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_q     <= ENG_IDLE;
         wel_q       <= WEL_RST;
         cyc_q       <= 16'h0000;
         pend_stat_q <= 1'b0;
         pend_bp_q   <= BP_SHIP;
         pend_arm_q  <= ARM_SHIP;
         pend_addr_q <= 11'h000;
         pend_data_q <= 8'h00;
         used_tog_q  <= 1'b0;
      end else begin
         if (cs_rise) begin
            used_tog_q <= frame_tog_q;                    // record consumed or refused
         end
         case (state_q)
            ENG_IDLE: begin
               cyc_q <= 16'h0000;
               if (take) begin
                  case (rec_code)
                     CMD_SET_WEL: begin
                        wel_q <= 1'b1;
                     end
                     CMD_CLR_WEL: begin
                        wel_q <= 1'b0;
                     end
                     CMD_WR_STAT: begin
                        if (stat_ok) begin                // else ignored
                           state_q     <= ENG_BUSY;
                           pend_stat_q <= 1'b1;
                           pend_bp_q   <= {rec_data_q[ST_BPH_BIT], rec_data_q[ST_BPL_BIT]};
                           pend_arm_q  <= arm_new;
                        end
                     end
                     CMD_WR_ARRAY: begin
                        if (arr_ok) begin
                           state_q     <= ENG_BUSY;
                           pend_stat_q <= 1'b0;
                           pend_addr_q <= rec_addr_q;
                           pend_data_q <= rec_data_q;
                        end
                     end
                     default: begin
                        wel_q <= wel_q;                   // reads leave no trace
                     end
                  endcase
               end
            end
            ENG_BUSY: begin
               cyc_q <= cyc_q + 16'h0001;
               if (cyc_end) begin
                  state_q <= ENG_IDLE;
                  wel_q   <= 1'b0;
               end
            end
            default: begin
               state_q <= ENG_IDLE;
            end
         endcase
      end
   end

   // nonvolatile status bits change together at the end of the cycle
   always_ff @(posedge clk_in) begin
      if (done && pend_stat_q) begin
         bp_q  <= pend_bp_q;
         arm_q <= pend_arm_q;
      end
   end

   // array commit; no reset, contents survive power-up
   always_ff @(posedge clk_in) begin
      if (done && !pend_stat_q) begin
         mem_q[pend_addr_q] <= pend_data_q;
      end
   end

endmodule : sesrc_core

// file: sesrc_checker_assertions.sv
// checker: link-level properties of the eeprom front end
`timescale 1ns/1ps
module sesrc_checker #(
   parameter int WRITE_CYC = 40 // write length in clk_in cycles
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic sck_in,
   input wire logic cs_n_in,
   input wire logic si_in,
   input wire logic wp_n_in,
   input wire logic so_out,
   input wire logic so_oe_n_out
);
   logic [5:0] cnt_q;     // rising edges seen in frame
   logic [7:0] op_q;      // op-code shifted in
   logic [7:0] sh_q;      // bits read back from so
   logic [7:0] b1_q;      // first status byte of frame
   logic       so_rise_q; // so at last rising edge
   wire stat_op = (op_q[7:4] == 4'h0) && (op_q[2:0] == 3'h5);
   wire rd_op   = (op_q[7:4] == 4'h0) && (op_q[2:0] == 3'h3);
   // frame trackers, cleared while deselected
   always_ff @(posedge sck_in or posedge cs_n_in) begin
      if (cs_n_in) begin
         cnt_q     <= 6'h00;
         op_q      <= 8'h00;
         sh_q      <= 8'h00;
         b1_q      <= 8'h00;
         so_rise_q <= 1'b0;
      end else begin
         cnt_q     <= (cnt_q == 6'h3f) ? cnt_q : cnt_q + 6'h01; // saturate
         op_q      <= (cnt_q < 6'h08) ? {op_q[6:0], si_in} : op_q;
         sh_q      <= {sh_q[6:0], so_out};
         b1_q      <= (cnt_q == 6'h10) ? sh_q : b1_q;
         so_rise_q <= so_out;
      end
   end
   a_idle_float: assert property (@(posedge clk_in) disable iff (rst_in)
      cs_n_in && $past(cs_n_in) |-> so_oe_n_out) else $error("so driven while idle");
   a_opcode_quiet: assert property (@(posedge sck_in) disable iff (rst_in || cs_n_in)
      cnt_q < 6'h08 |-> so_oe_n_out) else $error("so driven during op-code");
   a_status_drive: assert property (@(posedge sck_in) disable iff (rst_in || cs_n_in)
      stat_op && cnt_q >= 6'h08 |-> !so_oe_n_out) else $error("status not driven");
   a_addr_quiet: assert property (@(posedge sck_in) disable iff (rst_in || cs_n_in)
      !stat_op && cnt_q < 6'h18 |-> so_oe_n_out) else $error("so driven before data");
   a_write_silent: assert property (@(posedge sck_in) disable iff (rst_in || cs_n_in)
      !stat_op && !rd_op && cnt_q >= 6'h08 |-> so_oe_n_out) else $error("so driven on write");
   a_dontcare_zero: assert property (@(posedge sck_in) disable iff (rst_in || cs_n_in)
      stat_op && cnt_q == 6'h10 && sh_q != 8'hff |-> sh_q[6:4] == 3'h0)
      else $error("unused status bits set");
   a_busy_ones: assert property (@(posedge sck_in) disable iff (rst_in || cs_n_in)
      stat_op && cnt_q == 6'h10 && sh_q[0] |-> sh_q == 8'hff) else $error("busy status not ff");
   a_status_repeat: assert property (@(posedge sck_in) disable iff (rst_in || cs_n_in)
      stat_op && cnt_q == 6'h18 && b1_q != 8'hff && sh_q != 8'hff |-> sh_q == b1_q)
      else $error("status byte not repeated");
   a_fall_launch: assert property (@(negedge sck_in) disable iff (rst_in || cs_n_in)
      !so_oe_n_out |-> so_out == so_rise_q) else $error("so moved while sck high");
   c_status_read: cover property (@(posedge sck_in) stat_op && cnt_q == 6'h18);
   c_busy_seen: cover property (@(posedge sck_in) stat_op && cnt_q == 6'h10 && sh_q == 8'hff);
   c_array_read: cover property (@(posedge sck_in) rd_op && cnt_q == 6'h20);
endmodule : sesrc_checker

bind sesrc_core sesrc_checker #(.WRITE_CYC(WRITE_CYC)) i_sesrc_checker (.clk_in, .rst_in,
   .sck_in, .cs_n_in, .si_in, .wp_n_in, .so_out, .so_oe_n_out);

// file: sesrc_spi_master.sv
// partner: behavioural spi master, mode 0, 80 ns link clock
`timescale 1ns/1ps
module sesrc_spi_master (
   output logic      sck_out,
   output logic      cs_n_out,
   output logic      si_out,
   input  wire logic so_in
);
   initial begin
      sck_out  = 1'b0; // clock parked low outside frames
      cs_n_out = 1'b1;
      si_out   = 1'b0;
   end
   // one frame: tx left-justified, rx right-justified
   task automatic frame(input logic [39:0] tx, input int n, output logic [39:0] rx);
      rx = '0;
      #13 cs_n_out = 1'b0;
      for (int i = 0; i < n; i++) begin
         si_out = tx[39-i];
         #20 sck_out = 1'b1;
         rx = {rx[38:0], so_in};
         #40 sck_out = 1'b0;
         #20;
      end
      cs_n_out = 1'b1;
      si_out   = ~si_out;             // released line shows inverse
      #500;                           // engine must see the deselect
   endtask : frame
endmodule : sesrc_spi_master

// file: sesrc_core_bench.sv
// bench: drives the front end over the link and checks status and array
`timescale 1ns/1ps
module sesrc_core_bench;
   import sesrc_pkg::*;
   localparam int WCYC   = 40;             // shortened write cycle
   localparam int T_WAIT = WCYC*100 + 1000; // outlasts one write
   logic        clk_in, rst_in, wp_n_in;
   logic        sck_w, cs_n_w, si_w, so_w, so_oe_n_w;
   wire         so_pin = so_oe_n_w ? ~so_w : so_w; // undriven line shows the inverse
   int          fails, tests_run;
   logic [39:0] rx;
   sesrc_core #(.WRITE_CYC(WCYC)) i_sesrc_core (.clk_in(clk_in), .rst_in(rst_in),
      .sck_in(sck_w), .cs_n_in(cs_n_w), .si_in(si_w), .wp_n_in(wp_n_in),
      .so_out(so_w), .so_oe_n_out(so_oe_n_w));
   sesrc_spi_master i_sesrc_spi_master (.sck_out(sck_w), .cs_n_out(cs_n_w),
      .si_out(si_w), .so_in(so_pin));
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic close_out;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : close_out
   // link helpers; only defined op-codes, bit 3 low unless under test
   task automatic cmd(input logic [7:0] op);
      i_sesrc_spi_master.frame({op, 32'h0}, 8, rx);
   endtask : cmd
   task automatic wr_stat(input logic [7:0] d);
      i_sesrc_spi_master.frame({8'h01, d, 24'h0}, 16, rx);
   endtask : wr_stat
   task automatic rd_stat(input string what, input logic [7:0] exp);
      i_sesrc_spi_master.frame({8'h05, 32'h0}, 32, rx);
      check(what, rx[23:16], exp);
   endtask : rd_stat
   task automatic wr_arr(input logic [15:0] a, input logic [7:0] d);
      cmd(8'h06);
      i_sesrc_spi_master.frame({8'h05, 32'h0}, 16, rx);
      check("ready and latch", rx[7:0] & 8'h03, 8'h02);
      i_sesrc_spi_master.frame({8'h02, a, d, 8'h0}, 32, rx);
      #(T_WAIT);
   endtask : wr_arr
   task automatic rd_arr(input logic [15:0] a);
      i_sesrc_spi_master.frame({8'h03, a, 16'h0}, 40, rx);
   endtask : rd_arr
   task automatic t_power_up;
      rd_stat("status at power-up", 8'h00);
      wr_stat(8'h8c);
      #(T_WAIT);
      rd_stat("status write without latch", 8'h00);
      $display("test power_up done");
   endtask : t_power_up
   task automatic t_latch;
      for (int b = 0; b < 2; b++) begin
         cmd({4'h0, b[0], 3'h6});
         rd_stat("latch set", 8'h02);
         cmd({4'h0, b[0], 3'h4});
         rd_stat("latch cleared", 8'h00);
      end
      $display("test latch done");
   endtask : t_latch
   task automatic t_stat_write;
      cmd(8'h06);
      wr_stat(8'h74);
      rd_stat("status while busy", 8'hff);
      #(T_WAIT);
      rd_stat("status after write", 8'h04);
      $display("test stat_write done");
   endtask : t_stat_write
   task automatic t_array;
      wr_arr(16'h0000, 8'hc3);
      rd_stat("latch after array write", 8'h04);
      wr_arr(16'ha5ff, 8'h5a);
      wr_arr(16'h0600, 8'h3c);
      rd_stat("refused array write", 8'h06);
      rd_arr(16'h05ff);
      check("array 5ff", rx[15:8], 8'h5a);
      check("array 600 kept", {7'h0, rx[7:0] === 8'h3c}, 8'h00);
      rd_arr(16'hffff);
      check("array wrap", rx[7:0], 8'hc3);
      $display("test array done");
   endtask : t_array
   task automatic t_hw_protect;
      cmd(8'h06);
      wr_stat(8'h80);
      #(T_WAIT);
      rd_stat("arm set", 8'h80);
      @(negedge clk_in) wp_n_in = 1'b0;
      cmd(8'h06);
      wr_stat(8'h08);
      rd_stat("status locked", 8'h82);
      wr_arr(16'h0700, 8'h99);
      rd_arr(16'h0700);
      check("array under pin", rx[15:8], 8'h99);
      @(negedge clk_in) wp_n_in = 1'b1;
      cmd(8'h06);
      wr_stat(8'h00);
      #(T_WAIT);
      rd_stat("arm cleared", 8'h00);
      $display("test hw_protect done");
   endtask : t_hw_protect
   initial begin
      #600000;
      fails++;
      $display("watchdog expired");
      close_out;
   end
   initial begin
      rst_in    = 1'b1;
      wp_n_in   = 1'b1;
      fails     = 0;
      tests_run = 0;
      repeat (20) @(negedge clk_in);
      rst_in = 1'b0;
      repeat (3) @(negedge clk_in);
      t_power_up;
      t_latch;
      t_hw_protect;
      t_stat_write;
      t_array;
      close_out;
   end
endmodule : sesrc_core_bench
